/* design/flash_host_pkg.sv */
// Constants shared by the flash protection host controller.
package flash_host_pkg;
  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int T_SETUP_NS = 10;
  localparam int T_WP_NS = 35;
  localparam int T_HOLD_NS = 10;
  localparam int T_ACC_NS = 70;
  localparam int T_RP_NS = 500;
  localparam int T_RH_NS = 50;
  localparam int SYNC_DEPTH = 2;
  localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] WP_CYC = 8'((T_WP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] HOLD_CYC = 8'((T_HOLD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] ACC_CYC =
    8'((T_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_DEPTH);
  localparam logic [7:0] RP_CYC = 8'((T_RP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] RH_CYC = 8'((T_RH_NS * CLK_MHZ + 999) / 1000);

  // ----------------------------------------------------------------------
  // Register map of the controller
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_PINCTRL = 8'h14;
  localparam int ST_BUSY = 0;
  localparam int ST_SECURED = 1;
  localparam int ST_ERR = 2;
  localparam int ST_TMPUNP = 3;
  localparam int PC_WP_HIGH = 0;
  localparam int PC_TMPUNP = 1;
  localparam int PC_LOCK_HV = 2;

  // ----------------------------------------------------------------------
  // Operations and flash pin encodings
  // ----------------------------------------------------------------------
  localparam logic [3:0] OP_WRITE = 4'h1;
  localparam logic [3:0] OP_READ = 4'h2;
  localparam logic [3:0] OP_ENTER_SEC = 4'h3;
  localparam logic [3:0] OP_EXIT_SEC = 4'h4;
  localparam logic [3:0] OP_ID_READ = 4'h5;
  localparam logic [3:0] OP_PROT_CHECK = 4'h6;
  localparam logic [3:0] OP_SEC_LOCK = 4'h7;
  localparam logic [3:0] OP_HW_RESET = 4'h8;
  localparam int ADDR_W = 22;
  localparam int DQ_W = 16;
  localparam int ID_HV_BIT = 9;
  localparam int PROT_SEL_BIT = 6;
  localparam int ID_PAGE_BIT = 1;
  localparam int ID_CODE_BIT = 0;
  localparam int SECTOR_LSB = 16;
  localparam int FIRST_SECTOR_LSB = 15;
  localparam logic [21:0] UNLOCK_A1 = 22'h000555;
  localparam logic [21:0] UNLOCK_A2 = 22'h0002AA;
  localparam logic [15:0] UNLOCK_D1 = 16'h00AA;
  localparam logic [15:0] UNLOCK_D2 = 16'h0055;
  localparam logic [15:0] ENTER_SEC_D = 16'h0088;
  localparam logic [15:0] AUTOSEL_D = 16'h0090;
  localparam logic [15:0] EXIT_SEC_D = 16'h0000;
  localparam logic [15:0] PROTECT_D = 16'h0060;
  localparam logic [2:0] ENTER_LEN = 3'h3;
  localparam logic [2:0] EXIT_LEN = 3'h4;
endpackage : flash_host_pkg

/* design/sync_stage.sv */
// Two flip-flop synchroniser for a bus of asynchronous inputs.
`timescale 1ns/1ps
module sync_stage #(
  parameter int W = 16
) (
  input wire logic clk_i, // System clock.
  input wire logic [W-1:0] d_i, // Asynchronous input.
  output logic [W-1:0] q_o // Synchronised output.
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk_i) begin
    meta_q <= d_i;
    sync_q <= meta_q;
  end

  assign q_o = sync_q;
endmodule : sync_stage

/* design/flash_prot_host.sv */
// Host controller driving the protection and secured-region pins of a flash.
//
// Summary of operation
// - Identification read: high voltage, strobes and lines low.
// - Protect check returns one if protected, else zero.
// - Lock only after entering the secured region.
// - Exit secured region before using the array.
// - Address held from strobe fall, data past rise.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module flash_prot_host (
  input wire logic SYS_CLK_I, // 250 MHz clock.
  input wire logic RST_B_I, // Synchronous reset, active low.
  input wire logic [7:0] ADDR_I, // Register byte address.
  input wire logic [31:0] WDATA_I, // Register write data.
  input wire logic WR_I, // Write strobe.
  input wire logic RD_I, // Read strobe.
  output logic [31:0] RDATA_O, // Read data, cycle after strobe.
  output logic CE_B_O, // Flash chip select, active low.
  output logic OE_B_O, // Flash output enable, active low.
  output logic WE_B_O, // Flash write strobe, active low.
  output logic RESET_B_O, // Flash hardware reset, active low.
  output logic RESET_HV_O, // Raise reset pin to high id voltage.
  output logic ID_HV_O, // Raise id line to high id voltage.
  output logic WP_B_O, // Flash write protect, active low.
  output logic [21:0] FADDR_O, // Flash address lines.
  output logic [15:0] DQ_O, // Flash data out.
  output logic DQ_OE_O, // Flash data output enable.
  input wire logic [15:0] DQ_I // Flash data in.
);
  typedef enum logic [2:0] {
    S_IDLE, S_SETUP, S_PULSE, S_HOLD, S_RACC, S_RREC, S_RST, S_RH
  } state_e;

  typedef struct packed {
    state_e st;
    logic [7:0] cnt;
    logic [2:0] step;
    logic [3:0] op;
    logic [21:0] addr, fa;
    logic [15:0] wdata, rdata, dq;
    logic secured, err, wp_high, tmp_unp, lock_hv;
    logic [31:0] rd;
    logic ce_b, oe_b, we_b, rst_b, id_hv, dq_oe;
  } state_s;

  state_s s_q, s_d;
  logic [15:0] dq_sync, seq_dat;
  logic is_write_op, in_first;
  logic [2:0] seq_len;
  logic [21:0] seq_a;

  sync_stage #(.W(flash_host_pkg::DQ_W)) sync_stage_i (
    .clk_i(SYS_CLK_I),
    .d_i(DQ_I),
    .q_o(dq_sync)
  );

  // ----------------------------------------------------------------------
  // Bus cycle sequences
  // ----------------------------------------------------------------------
  always_comb begin
    is_write_op = (s_q.op == flash_host_pkg::OP_WRITE) ||
                  (s_q.op == flash_host_pkg::OP_ENTER_SEC) ||
                  (s_q.op == flash_host_pkg::OP_EXIT_SEC) ||
                  (s_q.op == flash_host_pkg::OP_SEC_LOCK);
    seq_len = 3'h1;
    seq_a = s_q.addr;
    seq_dat = s_q.wdata;
    if (s_q.op == flash_host_pkg::OP_ENTER_SEC) begin
      seq_len = flash_host_pkg::ENTER_LEN;
    end else if (s_q.op == flash_host_pkg::OP_EXIT_SEC) begin
      seq_len = flash_host_pkg::EXIT_LEN;
    end
    case (s_q.step)
      3'h0: begin
        if (seq_len != 3'h1) begin
          seq_a = flash_host_pkg::UNLOCK_A1;
          seq_dat = flash_host_pkg::UNLOCK_D1;
        end else if (s_q.op == flash_host_pkg::OP_SEC_LOCK) begin
          // Protect write with the page line high and the mode line low.
          seq_a = s_q.addr;
          seq_a[flash_host_pkg::PROT_SEL_BIT] = 1'b0;
          seq_a[flash_host_pkg::ID_PAGE_BIT] = 1'b1;
          seq_dat = flash_host_pkg::PROTECT_D;
        end
      end
      3'h1: begin
        seq_a = flash_host_pkg::UNLOCK_A2;
        seq_dat = flash_host_pkg::UNLOCK_D2;
      end
      3'h2: begin
        seq_a = flash_host_pkg::UNLOCK_A1;
        seq_dat = (s_q.op == flash_host_pkg::OP_ENTER_SEC) ?
                  flash_host_pkg::ENTER_SEC_D : flash_host_pkg::AUTOSEL_D;
      end
      default: begin
        seq_a = s_q.addr;
        seq_dat = flash_host_pkg::EXIT_SEC_D;
      end
    endcase
  end

  assign in_first = ~|s_q.addr[flash_host_pkg::ADDR_W-1:
                               flash_host_pkg::FIRST_SECTOR_LSB];

  // ----------------------------------------------------------------------
  // Controller state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (RD_I) begin
      case (ADDR_I)
        flash_host_pkg::REG_ADDR: s_d.rd = {10'h000, s_q.addr};
        flash_host_pkg::REG_WDATA: s_d.rd = {16'h0000, s_q.wdata};
        flash_host_pkg::REG_RDATA: s_d.rd = {16'h0000, s_q.rdata};
        flash_host_pkg::REG_STATUS: begin
          s_d.rd = 32'h0000_0000;
          s_d.rd[flash_host_pkg::ST_BUSY] = (s_q.st != S_IDLE);
          s_d.rd[flash_host_pkg::ST_SECURED] = s_q.secured;
          s_d.rd[flash_host_pkg::ST_ERR] = s_q.err;
          s_d.rd[flash_host_pkg::ST_TMPUNP] = s_q.tmp_unp;
        end
        flash_host_pkg::REG_PINCTRL: begin
          s_d.rd = 32'h0000_0000;
          s_d.rd[flash_host_pkg::PC_WP_HIGH] = s_q.wp_high;
          s_d.rd[flash_host_pkg::PC_TMPUNP] = s_q.tmp_unp;
          s_d.rd[flash_host_pkg::PC_LOCK_HV] = s_q.lock_hv;
        end
        default: s_d.rd = 32'h0000_0000;
      endcase
    end
    if (WR_I) begin
      case (ADDR_I)
        flash_host_pkg::REG_ADDR: s_d.addr = WDATA_I[21:0];
        flash_host_pkg::REG_WDATA: s_d.wdata = WDATA_I[15:0];
        flash_host_pkg::REG_STATUS: begin
          if (WDATA_I[flash_host_pkg::ST_ERR]) begin
            s_d.err = 1'b0;
          end
        end
        flash_host_pkg::REG_PINCTRL: begin
          s_d.wp_high = WDATA_I[flash_host_pkg::PC_WP_HIGH];
          s_d.tmp_unp = WDATA_I[flash_host_pkg::PC_TMPUNP];
          s_d.lock_hv = WDATA_I[flash_host_pkg::PC_LOCK_HV];
        end
        default: begin
        end
      endcase
    end
    s_d.cnt = (s_q.cnt != 8'h00) ? s_q.cnt - 8'h01 : 8'h00;
    case (s_q.st)
      S_IDLE: begin
        if (WR_I && ADDR_I == flash_host_pkg::REG_CMD) begin
          s_d.op = WDATA_I[3:0];
          s_d.step = 3'h0;
          s_d.cnt = flash_host_pkg::SETUP_CYC;
          s_d.st = S_SETUP;
          if (WDATA_I[3:0] == flash_host_pkg::OP_HW_RESET) begin
            s_d.st = S_RST;
            s_d.cnt = flash_host_pkg::RP_CYC;
          end else if (WDATA_I[3:0] == flash_host_pkg::OP_SEC_LOCK &&
                       !s_q.secured) begin
            s_d.st = S_IDLE;
            s_d.err = 1'b1;
          end else if ((WDATA_I[3:0] == flash_host_pkg::OP_READ ||
                        WDATA_I[3:0] == flash_host_pkg::OP_WRITE) &&
                       s_q.secured && !in_first) begin
            s_d.st = S_IDLE;
            s_d.err = 1'b1;
          end else if (WDATA_I[3:0] == 4'h0 || WDATA_I[3:0] >
                       flash_host_pkg::OP_HW_RESET) begin
            s_d.st = S_IDLE;
            s_d.err = 1'b1;
          end
        end
      end
      S_SETUP: begin
        s_d.ce_b = 1'b1;
        s_d.oe_b = 1'b1;
        s_d.we_b = 1'b1;
        s_d.dq_oe = is_write_op;
        s_d.fa = seq_a;
        s_d.dq = seq_dat;
        if (s_q.op == flash_host_pkg::OP_ID_READ ||
            s_q.op == flash_host_pkg::OP_PROT_CHECK) begin
          s_d.id_hv = 1'b1;
          s_d.fa[flash_host_pkg::PROT_SEL_BIT] = 1'b0;
          if (s_q.op == flash_host_pkg::OP_ID_READ) begin
            s_d.fa[flash_host_pkg::ID_PAGE_BIT] = 1'b0;
            s_d.fa[flash_host_pkg::ID_CODE_BIT] =
              s_q.addr[flash_host_pkg::ID_CODE_BIT];
          end else begin
            s_d.fa[flash_host_pkg::ID_PAGE_BIT] = 1'b1;
            s_d.fa[flash_host_pkg::ID_CODE_BIT] = 1'b0;
          end
          s_d.fa[flash_host_pkg::ID_HV_BIT] = 1'b1;
        end
        if (s_q.cnt == 8'h00) begin
          s_d.ce_b = 1'b0;
          if (is_write_op) begin
            s_d.we_b = 1'b0;
            s_d.cnt = flash_host_pkg::WP_CYC;
            s_d.st = S_PULSE;
          end else begin
            s_d.oe_b = 1'b0;
            s_d.cnt = flash_host_pkg::ACC_CYC;
            s_d.st = S_RACC;
          end
        end
      end
      S_PULSE: begin
        if (s_q.cnt == 8'h00) begin
          s_d.we_b = 1'b1;
          s_d.cnt = flash_host_pkg::HOLD_CYC;
          s_d.st = S_HOLD;
        end
      end
      S_HOLD: begin
        if (s_q.cnt == 8'h00) begin
          s_d.ce_b = 1'b1;
          s_d.dq_oe = 1'b0;
          s_d.step = s_q.step + 3'h1;
          s_d.cnt = flash_host_pkg::SETUP_CYC;
          s_d.st = S_SETUP;
          if (s_q.step + 3'h1 == seq_len) begin
            s_d.st = S_IDLE;
            if (s_q.op == flash_host_pkg::OP_ENTER_SEC) begin
              s_d.secured = 1'b1;
            end
            if (s_q.op == flash_host_pkg::OP_EXIT_SEC) begin
              s_d.secured = 1'b0;
            end
          end
        end
      end
      S_RACC: begin
        if (s_q.cnt == 8'h00) begin
          s_d.rdata = dq_sync;
          s_d.ce_b = 1'b1;
          s_d.oe_b = 1'b1;
          s_d.cnt = flash_host_pkg::HOLD_CYC;
          s_d.st = S_RREC;
        end
      end
      S_RREC: begin
        s_d.id_hv = 1'b0;
        if (s_q.cnt == 8'h00) begin
          s_d.st = S_IDLE;
        end
      end
      S_RST: begin
        s_d.rst_b = 1'b0;
        s_d.ce_b = 1'b1;
        s_d.oe_b = 1'b1;
        s_d.we_b = 1'b1;
        s_d.dq_oe = 1'b0;
        s_d.secured = 1'b0;
        if (s_q.cnt == 8'h00) begin
          s_d.rst_b = 1'b1;
          s_d.cnt = flash_host_pkg::RH_CYC;
          s_d.st = S_RH;
        end
      end
      S_RH: begin
        if (s_q.cnt == 8'h00) begin
          s_d.st = S_IDLE;
        end
      end
      default: s_d.st = S_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_B_I) begin
      s_q <= '0;
      s_q.st <= S_IDLE;
      s_q.ce_b <= 1'b1;
      s_q.oe_b <= 1'b1;
      s_q.we_b <= 1'b1;
      s_q.rst_b <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign RDATA_O = s_q.rd;
  assign CE_B_O = s_q.ce_b;
  assign OE_B_O = s_q.oe_b;
  assign WE_B_O = s_q.we_b;
  assign RESET_B_O = s_q.rst_b;
  // Lock may use the raised reset level only inside secured mode.
  assign RESET_HV_O = s_q.rst_b &&
    (s_q.tmp_unp || (s_q.lock_hv && s_q.secured));
  assign ID_HV_O = s_q.id_hv;
  assign WP_B_O = s_q.wp_high;
  assign FADDR_O = s_q.fa;
  assign DQ_O = s_q.dq;
  assign DQ_OE_O = s_q.dq_oe;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_id_read_pins: assert property (@(posedge SYS_CLK_I)
    disable iff (!RST_B_I) ID_HV_O && !OE_B_O &&
    s_q.op == flash_host_pkg::OP_ID_READ |->
    !CE_B_O && !FADDR_O[flash_host_pkg::PROT_SEL_BIT] &&
    !FADDR_O[flash_host_pkg::ID_PAGE_BIT]) else $error("id read pins");
  chk_prot_check_pins: assert property (@(posedge SYS_CLK_I)
    disable iff (!RST_B_I) ID_HV_O && !OE_B_O &&
    s_q.op == flash_host_pkg::OP_PROT_CHECK |->
    WE_B_O && FADDR_O[flash_host_pkg::ID_PAGE_BIT] &&
    !FADDR_O[flash_host_pkg::ID_CODE_BIT] &&
    !FADDR_O[flash_host_pkg::PROT_SEL_BIT])
    else $error("protect check pins");
  chk_addr_stable_we: assert property (@(posedge SYS_CLK_I)
    disable iff (!RST_B_I) !WE_B_O && $past(!WE_B_O) |->
    $stable(FADDR_O) && $stable(DQ_O)) else $error("address moved");
  chk_data_past_rise: assert property (@(posedge SYS_CLK_I)
    disable iff (!RST_B_I) $rose(WE_B_O) |-> DQ_OE_O && !CE_B_O ##1 DQ_OE_O)
    else $error("data dropped at rise");
  chk_lock_needs_sec: assert property (@(posedge SYS_CLK_I)
    disable iff (!RST_B_I) $fell(WE_B_O) &&
    s_q.op == flash_host_pkg::OP_SEC_LOCK |-> s_q.secured)
    else $error("lock outside secured mode");
  chk_array_after_exit: assert property (@(posedge SYS_CLK_I)
    disable iff (!RST_B_I) $fell(CE_B_O) && s_q.secured &&
    (s_q.op == flash_host_pkg::OP_READ ||
     s_q.op == flash_host_pkg::OP_WRITE) |-> in_first)
    else $error("array access in secured mode");
  cov_enter_sec: cover property (@(posedge SYS_CLK_I) $rose(s_q.secured));
  cov_id_read: cover property (@(posedge SYS_CLK_I)
    ID_HV_O && !OE_B_O ##1 OE_B_O);
  cov_hw_reset: cover property (@(posedge SYS_CLK_I) $rose(RESET_B_O));
endmodule : flash_prot_host

/* verif/flash_dev_model.sv */
// Behavioural flash device seen by the protection host controller.
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic [15:0] MAKER = 16'h005A, // Arbitrary value.
  parameter logic [15:0] PART = 16'h1234, // Arbitrary value.
  parameter logic [5:0] PROT_GROUP = 6'h05, // Group stored as protected.
  parameter logic FACTORY_LOCK = 1'b0 // Lock indicator, 0 customer-lockable.
) (
  input wire logic ce_b_i, // Chip select, active low.
  input wire logic oe_b_i, // Output enable, active low.
  input wire logic we_b_i, // Write strobe, active low.
  input wire logic rst_b_i, // Hardware reset, active low.
  input wire logic reset_hv_i, // Reset pin at high id voltage.
  input wire logic id_hv_i, // Id line at high id voltage.
  input wire logic wp_b_i, // Write protect, active low.
  input wire logic [21:0] addr_i, // Address lines.
  input wire logic [15:0] dq_i, // Data from the host.
  input wire logic dq_oe_i, // Host drives data.
  output logic [15:0] dq_o, // Data towards the host.
  output int bad_o // Count of broken bus cycles.
);
  logic [15:0] mem [logic [21:0]];
  logic [15:0] sec [0:127];
  logic [63:0] stored;
  logic sec_mode = 1'b0;
  logic sec_lock = 1'b0;
  logic vcc_ok = 1'b1;
  logic pu = 1'b1;
  logic [2:0] st = 3'h0;
  logic [21:0] la;
  logic [15:0] last = 16'h0;
  realtime tf;
  wire wr_b = ce_b_i | we_b_i | ~oe_b_i;
  wire drive = ~ce_b_i & ~oe_b_i & rst_b_i;

  function automatic logic prot(input logic [21:0] a);
    return (!wp_b_i && a[21:15] == 7'h00) ||
      (stored[a[21:16]] && !reset_hv_i);
  endfunction : prot

  function automatic logic [15:0] rdv(input logic [21:0] a);
    if (id_hv_i) begin
      if (a[1]) return {15'h0, prot(a)};
      return a[0] ? PART : MAKER;
    end
    if (st == 3'h4 && a[7:0] == 8'h03)
      return {8'h00, FACTORY_LOCK, 7'h08};
    if (sec_mode && a[21:15] == 7'h00) return sec[a[6:0]];
    return mem.exists(a) ? mem[a] : ~a[15:0];
  endfunction : rdv

  initial begin
    bad_o = 0;
    stored = 64'h0;
    stored[PROT_GROUP] = 1'b1;
    for (int i = 0; i < 128; i++) sec[i] = 16'hE500 + 16'(i);
  end

  assign dq_o = drive ? rdv(addr_i) : ~last;
  always @(negedge drive) last = rdv(addr_i);
  always @(posedge (drive & dq_oe_i)) bad_o++;
  always @(negedge rst_b_i) begin
    st = 3'h0;
    sec_mode = 1'b0;
  end
  always @(negedge wr_b) begin
    if ($realtime > 0) pu = 1'b0;
    tf = $realtime;
    la = addr_i;
  end
  always @(posedge wr_b) begin
    if (!pu && vcc_ok && rst_b_i && $realtime - tf >= 5.0) begin
      if (!dq_oe_i || la !== addr_i) bad_o++;
      case (st)
        3'h0: begin
          if (sec_mode && dq_i == 16'h0060 && !la[6] && la[1]) sec_lock = 1'b1;
          st = (la[10:0] == 11'h555 && dq_i == 16'h00AA) ? 3'h1 : 3'h0;
        end
        3'h1: st = (la[10:0] == 11'h2AA && dq_i == 16'h0055) ? 3'h2 : 3'h0;
        3'h2: begin
          if (la[10:0] == 11'h555 && dq_i == 16'h0088) sec_mode = 1'b1;
          st = 3'h0;
          if (la[10:0] == 11'h555 && dq_i == 16'h0090) st = 3'h4;
          if (la[10:0] == 11'h555 && dq_i == 16'h00A0) st = 3'h3;
        end
        3'h3: begin
          if (sec_mode && la[21:15] == 7'h00) begin
            if (!sec_lock) sec[la[6:0]] = dq_i;
          end else if (!prot(la)) mem[la] = dq_i;
          st = 3'h0;
        end
        default: begin
          if (dq_i == 16'h0000) sec_mode = 1'b0;
          st = 3'h0;
        end
      endcase
    end
  end
endmodule : flash_dev_model

/* verif/tb_flash_prot_host.sv */
// Self-checking bench for the flash protection host controller.
`timescale 1ns/1ps
module tb_flash_prot_host;
  localparam logic [15:0] MAKER = 16'h005A; // Arbitrary value.
  localparam logic [15:0] PART = 16'h1234; // Arbitrary value.
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic ce_b, oe_b, we_b, res_b, res_hv, id_hv, wp_b, dq_oe;
  logic [21:0] faddr;
  logic [15:0] dq_o, dq_i, v, d;
  logic [32:0] exp_q [$];
  logic [32:0] e;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int bad;

  flash_prot_host flash_prot_host_i (.SYS_CLK_I(sys_clk), .RST_B_I(rst_b),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .CE_B_O(ce_b), .OE_B_O(oe_b), .WE_B_O(we_b), .RESET_B_O(res_b),
    .RESET_HV_O(res_hv), .ID_HV_O(id_hv), .WP_B_O(wp_b), .FADDR_O(faddr),
    .DQ_O(dq_o), .DQ_OE_O(dq_oe), .DQ_I(dq_i));
  flash_dev_model #(.MAKER(MAKER), .PART(PART), .PROT_GROUP(6'h05))
    flash_dev_model_i (.ce_b_i(ce_b), .oe_b_i(oe_b), .we_b_i(we_b),
    .rst_b_i(res_b), .reset_hv_i(res_hv), .id_hv_i(id_hv), .wp_b_i(wp_b),
    .addr_i(faddr), .dq_i(dq_o), .dq_oe_i(dq_oe), .dq_o(dq_i), .bad_o(bad));

  initial forever #2 sys_clk = ~sys_clk;

  task automatic stop_test();
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string nm, input logic [31:0] ex, got);
    n_tests++;
    if (got !== ex) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : check

  // ---------------------------------------------------------------------
  // Register bus and flash operations
  // ---------------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] dt);
    addr <= a;
    wdata <= dt;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic c, logic [31:0] ex);
    exp_q.push_back({c, ex});
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(posedge sys_clk);
    v = rdata[15:0];
  endtask : rd_reg

  task automatic run(input logic [3:0] op, input logic [21:0] a,
    input logic [15:0] dt);
    wr_reg(flash_host_pkg::REG_ADDR, {10'h0, a});
    wr_reg(flash_host_pkg::REG_WDATA, {16'h0, dt});
    wr_reg(flash_host_pkg::REG_CMD, {28'h0, op});
    for (int i = 0; i < 100; i++) begin
      rd_reg(flash_host_pkg::REG_STATUS, 1'b0, 32'h0);
      if (v[flash_host_pkg::ST_BUSY] === 1'b0) break;
    end
  endtask : run

  task automatic prog(input logic [21:0] a, input logic [15:0] dt);
    run(flash_host_pkg::OP_WRITE, 22'h000555, 16'h00AA);
    run(flash_host_pkg::OP_WRITE, 22'h0002AA, 16'h0055);
    run(flash_host_pkg::OP_WRITE, 22'h000555, 16'h00A0);
    run(flash_host_pkg::OP_WRITE, a, dt);
  endtask : prog

  task automatic rd_op(input logic [3:0] op, input logic [21:0] a,
    input logic [15:0] ex);
    run(op, a, 16'h0);
    rd_reg(flash_host_pkg::REG_RDATA, 1'b1, {16'h0, ex});
  endtask : rd_op

  task automatic stat(input logic [31:0] ex);
    rd_reg(flash_host_pkg::REG_STATUS, 1'b1, ex);
  endtask : stat

  always @(posedge sys_clk) begin
    rd_d <= rd;
    cyc <= cyc + 1;
    if (rd_d) begin
      e = exp_q.pop_front();
      if (e[32]) check("rdata", e[31:0], rdata);
    end
    if (cyc == 60000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    void'($urandom(32'h33062747));
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    check("pins", 32'h3C,
      {26'h0, ce_b, oe_b, we_b, res_b, id_hv, wp_b});
    stat(32'h0);
    rd_reg(flash_host_pkg::REG_PINCTRL, 1'b1, 32'h0);
    rd_reg(8'h3C, 1'b1, 32'h0);
    rd_op(flash_host_pkg::OP_ID_READ, 22'h0, MAKER);
    rd_op(flash_host_pkg::OP_ID_READ, 22'h1, PART);
    rd_op(flash_host_pkg::OP_PROT_CHECK, 22'h0, 16'h1);
    rd_op(flash_host_pkg::OP_PROT_CHECK, 22'h050000, 16'h1);
    rd_op(flash_host_pkg::OP_PROT_CHECK, 22'h060000, 16'h0);
    d = 16'($urandom);
    prog(22'h000020, d);
    rd_op(flash_host_pkg::OP_READ, 22'h000020, 16'hFFDF);
    wr_reg(flash_host_pkg::REG_PINCTRL, 32'h1);
    rd_op(flash_host_pkg::OP_PROT_CHECK, 22'h0, 16'h0);
    prog(22'h000020, d);
    rd_op(flash_host_pkg::OP_READ, 22'h000020, d);
    prog(22'h050010, d);
    rd_op(flash_host_pkg::OP_READ, 22'h050010, 16'hFFEF);
    wr_reg(flash_host_pkg::REG_PINCTRL, 32'h3);
    stat(32'h8);
    prog(22'h050010, d);
    rd_op(flash_host_pkg::OP_READ, 22'h050010, d);
    wr_reg(flash_host_pkg::REG_PINCTRL, 32'h1);
    rd_op(flash_host_pkg::OP_PROT_CHECK, 22'h050000, 16'h1);
    prog(22'h050012, ~d);
    rd_op(flash_host_pkg::OP_READ, 22'h050012, 16'hFFED);
    run(flash_host_pkg::OP_WRITE, 22'h000555, 16'h00AA);
    run(flash_host_pkg::OP_WRITE, 22'h0002AA, 16'h0055);
    run(flash_host_pkg::OP_WRITE, 22'h060040, d);
    rd_op(flash_host_pkg::OP_READ, 22'h060040, 16'hFFBF);
    run(flash_host_pkg::OP_WRITE, 22'h000555, 16'h00AA);
    run(flash_host_pkg::OP_WRITE, 22'h0002AA, 16'h0055);
    run(flash_host_pkg::OP_WRITE, 22'h000555, 16'h0090);
    rd_op(flash_host_pkg::OP_READ, 22'h000003, 16'h0008);
    run(flash_host_pkg::OP_WRITE, 22'h000000, 16'h00F0);
    run(flash_host_pkg::OP_ENTER_SEC, 22'h0, 16'h0);
    stat(32'h2);
    rd_op(flash_host_pkg::OP_READ, 22'h000005, 16'hE505);
    run(flash_host_pkg::OP_READ, 22'h060000, 16'h0);
    stat(32'h6);
    wr_reg(flash_host_pkg::REG_STATUS, 32'h4);
    stat(32'h2);
    prog(22'h000009, d);
    rd_op(flash_host_pkg::OP_READ, 22'h000009, d);
    wr_reg(flash_host_pkg::REG_PINCTRL, 32'h5);
    check("reset_hv", 32'h1, {31'h0, res_hv});
    rd_reg(flash_host_pkg::REG_PINCTRL, 1'b1, 32'h5);
    run(flash_host_pkg::OP_SEC_LOCK, 22'h000002, 16'h0);
    prog(22'h00000A, d);
    rd_op(flash_host_pkg::OP_READ, 22'h00000A, 16'hE50A);
    run(flash_host_pkg::OP_EXIT_SEC, 22'h0, 16'h0);
    stat(32'h0);
    check("reset_hv", 32'h0, {31'h0, res_hv});
    rd_op(flash_host_pkg::OP_READ, 22'h000005, 16'hFFFA);
    run(flash_host_pkg::OP_SEC_LOCK, 22'h000002, 16'h0);
    stat(32'h4);
    wr_reg(flash_host_pkg::REG_STATUS, 32'h4);
    run(flash_host_pkg::OP_ENTER_SEC, 22'h0, 16'h0);
    run(flash_host_pkg::OP_HW_RESET, 22'h0, 16'h0);
    stat(32'h0);
    rd_op(flash_host_pkg::OP_READ, 22'h000005, 16'hFFFA);
    check("bus", 32'h0, 32'(bad));
    stop_test();
  end
endmodule : tb_flash_prot_host
